// *** scp_regs.vh ***
/*
  constants for the serial command port: frame format, baud timing,
  receive queue size.
  assumes a 20 MHz core clock; included by bare name.
*/
`ifndef SCP_REGS_VH
`define SCP_REGS_VH

// ***********************************************************************
// frame format
// ***********************************************************************
`define SCP_DATA_BITS     4'h8
`define SCP_RX_DEPTH      4
`define SCP_CLK_HZ        20000000
`define SCP_BAUD_FAST     115200
`define SCP_BAUD_SLOW     19200
// cycles per bit, rounded to nearest
`define SCP_DIV_FAST      ((`SCP_CLK_HZ + `SCP_BAUD_FAST/2) / `SCP_BAUD_FAST)
`define SCP_DIV_SLOW      ((`SCP_CLK_HZ + `SCP_BAUD_SLOW/2) / `SCP_BAUD_SLOW)

`endif

// *** scp_buf2.v ***
/*
  two-entry valid/ready buffer, parameter width.
  assumes one clock, synchronous active-low reset, clock enable.
*/
`default_nettype none

module scp_buf2 #(
  parameter W = 8
) (
  // clock and reset
  input  wire         clk_in,
  input  wire         resetn_in,
  input  wire         ce_in,
  // fill side
  input  wire         in_valid_in,
  output wire         in_ready_out,
  input  wire [W-1:0] in_data_in,
  // drain side
  output wire         out_valid_out,
  input  wire         out_ready_in,
  output wire [W-1:0] out_data_out
);

  reg [W-1:0] slot0;
  reg [W-1:0] slot1;
  reg [1:0]   count;
  reg         room;
  wire [1:0]  next_count;
  wire        push;
  wire        pop;

  // ready comes from a flop so the fill side sees a registered signal
  assign in_ready_out  = room;
  assign next_count    = count + {1'b0, push} - {1'b0, pop};
  assign out_valid_out = (count != 2'h0);
  assign out_data_out  = slot0;
  assign push = in_valid_in & in_ready_out;
  assign pop  = out_valid_out & out_ready_in;

  // slot0 is the head, slot1 the second word
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      count <= 2'h0;
      room  <= 1'b1;
      slot0 <= {W{1'b0}};
      slot1 <= {W{1'b0}};
    end
    else if (ce_in)
    begin
      if (pop)
      begin
        slot0 <= (count == 2'h2) ? slot1 : in_data_in;
        if (push && count == 2'h2)
          slot1 <= in_data_in;
      end
      else if (push)
      begin
        if (count == 2'h0)
          slot0 <= in_data_in;
        else
          slot1 <= in_data_in;
      end
      count <= next_count;
      room  <= (next_count != 2'h2);
    end
  end

endmodule

`default_nettype wire

// *** scp_uart.v ***
/*
  serial command port: 8n1 receiver and transmitter with rts/cts
  hardware handshake, four-byte receive queue, two-entry transmit buffer.
  assumes synchronous inputs at 20 MHz and a command processor that
  pulls received bytes and pushes response bytes with valid/ready.
*/
// Function
// - characters carry eight data bits, no parity and one stop bit.
// - the bit rate is 115k normally and 19.2k with the select jumper fitted.
// - received characters wait in a four-byte first-in first-out queue.
// - cts is high in reset and when the queue has at most one slot left, else low.
// - no new character is started while rts from the host is high.
// - every frame opens with exactly one start bit.
// - a mode input picks waiting or discarding when transmit is blocked.
`default_nettype none
`include "scp_regs.vh"

module scp_uart #(
  parameter RX_DEPTH = `SCP_RX_DEPTH,
  parameter DIV_FAST = `SCP_DIV_FAST,
  parameter DIV_SLOW = `SCP_DIV_SLOW
) (
  // clock, reset, enable
  input  wire       clk_in,
  input  wire       resetn_in,
  input  wire       ce_in,
  // configuration
  input  wire       slow_baud_in,
  input  wire       drop_on_block_in,
  // serial pins
  input  wire       rxd_in,
  output reg        txd_out,
  input  wire       rts_in,
  output reg        cts_out,
  // received bytes to command processor
  output reg        rx_valid_out,
  input  wire       rx_ready_in,
  output reg  [7:0] rx_data_out,
  // response bytes from command processor
  input  wire       tx_valid_in,
  output wire       tx_ready_out,
  input  wire [7:0] tx_data_in,
  // status
  output reg        rx_frame_err_out,
  output reg        tx_dropped_out
);

  // ***********************************************************************
  // bit timing
  // ***********************************************************************
  localparam [15:0] DIVF = DIV_FAST[15:0];
  localparam [15:0] DIVS = DIV_SLOW[15:0];
  wire [15:0] bit_len  = slow_baud_in ? DIVS : DIVF;
  wire [15:0] half_len = {1'b0, bit_len[15:1]};

  // ***********************************************************************
  // receiver
  // ***********************************************************************
  localparam [1:0] RX_IDLE = 2'h0;
  localparam [1:0] RX_START = 2'h1;
  localparam [1:0] RX_DATA = 2'h2;
  localparam [1:0] RX_STOP = 2'h3;

  reg [1:0]  rx_state;
  reg [15:0] rx_cnt;
  reg [3:0]  rx_bit;
  reg [7:0]  rx_shift;
  reg [7:0]  fifo [0:RX_DEPTH-1];
  reg [2:0]  wr_ptr;
  reg [2:0]  rd_ptr;
  reg [3:0]  fill;
  wire       fifo_full  = (fill == RX_DEPTH);
  wire       fifo_empty = (fill == 4'h0);
  reg        rx_push;
  wire       rx_pop = rx_valid_out & rx_ready_in;

  // frame receiver, sampling each bit at its middle
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      rx_state <= RX_IDLE;
      rx_cnt   <= 16'h0000;
      rx_bit   <= 4'h0;
      rx_shift <= 8'h00;
      rx_push  <= 1'b0;
      rx_frame_err_out <= 1'b0;
    end
    else if (ce_in)
    begin
      rx_push <= 1'b0;
      case (rx_state)
        RX_IDLE:
        begin
          rx_cnt <= 16'h0000;
          if (!rxd_in)
            rx_state <= RX_START;
        end
        RX_START:
        begin
          if (rx_cnt == half_len)
          begin
            rx_cnt <= 16'h0000;
            rx_bit <= 4'h0;
            rx_state <= rxd_in ? RX_IDLE : RX_DATA;  // glitch rejected
          end
          else
            rx_cnt <= rx_cnt + 16'h0001;
        end
        RX_DATA:
        begin
          if (rx_cnt == bit_len - 16'h0001)
          begin
            rx_cnt   <= 16'h0000;
            rx_shift <= {rxd_in, rx_shift[7:1]};
            rx_bit   <= rx_bit + 4'h1;
            if (rx_bit == `SCP_DATA_BITS - 4'h1)
              rx_state <= RX_STOP;
          end
          else
            rx_cnt <= rx_cnt + 16'h0001;
        end
        default:
        begin
          if (rx_cnt == bit_len - 16'h0001)
          begin
            rx_state <= RX_IDLE;
            rx_push  <= rxd_in & ~fifo_full;
            rx_frame_err_out <= ~rxd_in;
          end
          else
            rx_cnt <= rx_cnt + 16'h0001;
        end
      endcase
    end
  end

  // ***********************************************************************
  // receive queue and handshake
  // ***********************************************************************
  // four-byte ring; head held in an output register
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
      fill   <= 4'h0;
      rx_valid_out <= 1'b0;
      rx_data_out  <= 8'h00;
      cts_out      <= 1'b1;
    end
    else if (ce_in)
    begin
      if (rx_push)
      begin
        fifo[wr_ptr[1:0]] <= rx_shift;
        wr_ptr <= (wr_ptr == RX_DEPTH - 1) ? 3'h0 : wr_ptr + 3'h1;
      end
      if (!rx_valid_out || rx_pop)
      begin
        rx_valid_out <= ~fifo_empty;
        if (!fifo_empty)
        begin
          rx_data_out <= fifo[rd_ptr[1:0]];
          rd_ptr <= (rd_ptr == RX_DEPTH - 1) ? 3'h0 : rd_ptr + 3'h1;
        end
      end
      fill <= fill + {3'h0, rx_push}
              - {3'h0, (!rx_valid_out || rx_pop) && !fifo_empty};
      // high when the queue has at most one slot left
      cts_out <= (fill >= RX_DEPTH - 1);
    end
  end

  // ***********************************************************************
  // transmitter
  // ***********************************************************************
  wire       tb_valid;
  wire [7:0] tb_data;
  reg        tb_take;

  scp_buf2 #(
    .W (8)
  ) u_txbuf (
    .clk_in        (clk_in),
    .resetn_in     (resetn_in),
    .ce_in         (ce_in),
    .in_valid_in   (tx_valid_in),
    .in_ready_out  (tx_ready_out),
    .in_data_in    (tx_data_in),
    .out_valid_out (tb_valid),
    .out_ready_in  (tb_take),
    .out_data_out  (tb_data)
  );

  reg        tx_busy;
  reg [15:0] tx_cnt;
  reg [3:0]  tx_bit;
  reg [9:0]  tx_frame;

  always @*
  begin
    tb_take = tb_valid & ~tx_busy & (~rts_in | drop_on_block_in);
  end

  // frame sender: start, eight data lsb first, stop
  always @(posedge clk_in)
  begin
    if (!resetn_in)
    begin
      tx_busy  <= 1'b0;
      tx_cnt   <= 16'h0000;
      tx_bit   <= 4'h0;
      tx_frame <= 10'h3ff;
      txd_out  <= 1'b1;
      tx_dropped_out <= 1'b0;
    end
    else if (ce_in)
    begin
      tx_dropped_out <= 1'b0;
      if (!tx_busy)
      begin
        txd_out <= 1'b1;
        if (tb_take && rts_in)
          tx_dropped_out <= 1'b1;
        else if (tb_take)
        begin
          tx_busy  <= 1'b1;
          tx_frame <= {1'b1, tb_data, 1'b0};
          tx_cnt   <= 16'h0000;
          tx_bit   <= 4'h0;
          txd_out  <= 1'b0;
        end
      end
      else if (tx_cnt == bit_len - 16'h0001)
      begin
        tx_cnt <= 16'h0000;
        if (tx_bit == `SCP_DATA_BITS + 4'h1)
        begin
          tx_busy <= 1'b0;
          txd_out <= 1'b1;
        end
        else
        begin
          tx_bit  <= tx_bit + 4'h1;
          txd_out <= tx_frame[tx_bit + 4'h1];
        end
      end
      else
        tx_cnt <= tx_cnt + 16'h0001;
    end
  end

endmodule

`default_nettype wire

// *** scp_uart_assertions.sv ***
/* port checker for scp_uart.
   assumes ce_in held high by the bench. */
`default_nettype none
module scp_uart_chk #(
  parameter DIV_FAST = 174
) (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       resetn_in,
  // pins and mode
  input wire logic       txd_out,
  input wire logic       rts_in,
  input wire logic       cts_out,
  input wire logic       drop_on_block_in,
  // handshakes
  input wire logic       rx_valid_out,
  input wire logic       rx_ready_in,
  input wire logic [7:0] rx_data_out,
  input wire logic       tx_dropped_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // **********
  // checks
  // **********
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [15:0] lo;
  // length of the current low run on txd
  always @(posedge clk_in) lo <= txd_out ? 16'h0 : lo + 16'h1;
  property p_idle; $rose(resetn_in) |-> txd_out && cts_out; endproperty
  a_idle: assert property (p_idle) else $error("bad reset levels");
  property p_start; $fell(txd_out) |-> !txd_out [*8]; endproperty
  a_start: assert property (p_start) else $error("short start");
  property p_cell; $rose(txd_out) |-> lo >= DIV_FAST; endproperty
  a_cell: assert property (p_cell) else $error("short bit");
  property p_rts;
    $past(rts_in) && !$past(drop_on_block_in) |-> !$fell(txd_out);
  endproperty
  a_rts: assert property (p_rts) else $error("sent while held");
  property p_hold;
    rx_valid_out && !rx_ready_in |=> rx_valid_out && $stable(rx_data_out);
  endproperty
  a_hold: assert property (p_hold) else $error("rx word lost");
  property p_drop;
    tx_dropped_out |-> drop_on_block_in && $past(rts_in);
  endproperty
  a_drop: assert property (p_drop) else $error("bad discard");
  property p_ctsup; $rose(cts_out) |-> rx_valid_out; endproperty
  a_ctsup: assert property (p_ctsup) else $error("cts high empty");
  property p_ctsdn; !rx_valid_out [*4] |-> !cts_out; endproperty
  a_ctsdn: assert property (p_ctsdn) else $error("cts stuck");
  c_drop: cover property (tx_dropped_out);
  c_cts: cover property ($rose(cts_out));
  c_rx: cover property (rx_valid_out && rx_ready_in);
endmodule
bind scp_uart scp_uart_chk #(.DIV_FAST(DIV_FAST)) u_chk (.*);
`default_nettype wire

// *** scp_host.sv ***
/* host serial port model: 8n1 sender that obeys cts, receiver.
   assumes bit_len set by the bench. */
`default_nettype none
module scp_host (
  // clock
  input  wire logic clk_in,
  // serial pins
  input  wire logic txd_in,
  input  wire logic cts_in,
  output var  logic rxd_out,
  output var  logic rts_out
);
  timeunit 1ns;
  timeprecision 1ns;
  int         bit_len = 16;
  logic [7:0] got [$];
  logic [7:0] b;
  initial rxd_out = 1'b1;
  initial rts_out = 1'b0;
  // **********
  // receiver: mid-cell samples, lsb first
  // **********
  always
  begin
    @(negedge txd_in);
    repeat (bit_len / 2) @(posedge clk_in);
    for (int i = 0; i < 9; i++)
    begin
      repeat (bit_len) @(posedge clk_in);
      if (i < 8) b[i] = txd_in;
    end
    got.push_back(b);
  end
  // sender: start, eight bits, stop (low when bad)
  task automatic send(input logic [7:0] d, input logic bad);
    logic [9:0] f;
    f = {~bad, d, 1'b0};
    while (cts_in) @(negedge clk_in);
    for (int i = 0; i < 10; i++)
    begin
      rxd_out = f[i];
      repeat (bit_len) @(negedge clk_in);
    end
    rxd_out = 1'b1; // back to idle, also after a low stop bit
  endtask
endmodule
`default_nettype wire

// *** scp_uart_tb_top.sv ***
/* bench for scp_uart: random and corner bytes both ways.
   assumes scp_host as the far side. */
`default_nettype none
module scp_uart_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam DF = 16;
  localparam DS = 24;
  logic clk_in = 1'b0, resetn_in = 1'b0, ce_in = 1'b1;
  logic slow_baud_in = 1'b0, drop_on_block_in = 1'b0;
  logic rx_ready_in = 1'b0, tx_valid_in = 1'b0;
  logic [7:0] tx_data_in = 8'h00, rx_data_out, v [6];
  logic rxd_in, txd_out, rts_in, cts_out, rx_valid_out, tx_ready_out;
  logic rx_frame_err_out, tx_dropped_out;
  logic [31:0] seed = 32'h17ab3af2;
  int error_cnt = 0, check_count = 0, drops = 0;
  // **********
  // clock, parts, helpers
  // **********
  always #25 clk_in = ~clk_in;
  scp_uart #(.DIV_FAST(DF), .DIV_SLOW(DS)) dut (.*);
  scp_host host (.clk_in(clk_in), .txd_in(txd_out), .cts_in(cts_out),
    .rxd_out(rxd_in), .rts_out(rts_in));
  // count discard pulses
  always @(negedge clk_in) if (tx_dropped_out === 1'b1) drops++;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  task automatic chk(input logic [7:0] a, input logic [7:0] e);
    check_count++;
    if (a !== e)
    begin
      error_cnt++;
      $display("BAD t=%0t got %h exp %h", $time, a, e);
    end
  endtask
  task automatic push(input logic [7:0] d);
    @(negedge clk_in);
    tx_valid_in = 1'b1;
    tx_data_in = d;
    repeat (4000) if (!tx_ready_out) @(negedge clk_in);
    chk({7'h0, tx_ready_out}, 8'h01);
    @(negedge clk_in);
    tx_valid_in = 1'b0;
  endtask
  task automatic pop(input logic [7:0] e);
    repeat (4000) if (!rx_valid_out) @(negedge clk_in);
    chk({7'h0, rx_valid_out}, 8'h01);
    chk(rx_data_out, e);
    rx_ready_in = 1'b1;
    @(negedge clk_in);
    rx_ready_in = 1'b0;
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // watchdog
  initial
  begin
    #2000000;
    error_cnt++;
    final_report();
  end
  // main sequence
  initial
  begin
    repeat (8) @(negedge clk_in);
    chk({6'h0, txd_out, cts_out}, 8'h03);
    resetn_in = 1'b1;
    repeat (3) @(negedge clk_in);
    chk({7'h0, cts_out}, 8'h00);
    for (int i = 0; i < 6; i++)
    begin
      seed = xs(seed);
      v[i] = seed[7:0];
    end
    v[0] = 8'h01;
    v[1] = 8'h80;
    fork
      for (int i = 0; i < 6; i++) host.send(v[i], 1'b0);
    join_none
    repeat (60 * DF) @(negedge clk_in);
    chk({7'h0, cts_out}, 8'h01);
    for (int i = 0; i < 6; i++) pop(v[i]);
    // let the last forked frame finish its stop bit first
    repeat (DF) @(negedge clk_in);
    host.send(8'h5a, 1'b1);
    repeat (DF) @(negedge clk_in);
    chk({7'h0, rx_frame_err_out}, 8'h01);
    host.send(8'h3c, 1'b0);
    pop(8'h3c);
    chk({7'h0, rx_frame_err_out}, 8'h00);
    host.rts_out = 1'b1;
    push(v[2]);
    push(v[3]);
    repeat (4 * DF) @(negedge clk_in);
    chk({6'h0, tx_ready_out, txd_out}, 8'h01);
    host.rts_out = 1'b0;
    repeat (25 * DF) @(negedge clk_in);
    chk(host.got.pop_front(), v[2]);
    chk(host.got.pop_front(), v[3]);
    drop_on_block_in = 1'b1;
    host.rts_out = 1'b1;
    push(v[4]);
    push(v[5]);
    repeat (4 * DF) @(negedge clk_in);
    chk(8'(drops), 8'h02);
    chk(8'(host.got.size()), 8'h00);
    drop_on_block_in = 1'b0;
    host.rts_out = 1'b0;
    slow_baud_in = 1'b1;
    host.bit_len = DS;
    push(v[0]);
    repeat (12 * DS) @(negedge clk_in);
    chk(host.got.pop_front(), v[0]);
    host.send(v[1], 1'b0);
    pop(v[1]);
    final_report();
  end
endmodule
`default_nettype wire
